/* File: inc/adre_defs.vh */
`ifndef ADRE_DEFS_VH
`define ADRE_DEFS_VH

// ==========================================================
// register byte offsets
`define ADRE_REG_CMD 8'h00
`define ADRE_REG_FEAT 8'h04
`define ADRE_REG_SCNT 8'h08
`define ADRE_REG_LBA_LO 8'h0c
`define ADRE_REG_LBA_HI 8'h10
`define ADRE_REG_DEVHEAD 8'h14
`define ADRE_REG_STATUS 8'h18
`define ADRE_REG_ERROR 8'h1c
`define ADRE_REG_XMODE 8'h20
`define ADRE_REG_INT_STAT 8'h24
`define ADRE_REG_INT_MASK 8'h28
`define ADRE_REG_TAG 8'h2c

// ==========================================================
// opcodes
`define ADRE_OP_READ_DMA 8'hc8
`define ADRE_OP_READ_DMA_EXT 8'h25
`define ADRE_OP_READ_FPDMA 8'h60

// ==========================================================
// field positions
`define ADRE_ST_ERR 0
`define ADRE_ST_DRQ 3
`define ADRE_ST_DRDY 6
`define ADRE_ST_BSY 7
`define ADRE_ER_ABRT 2
`define ADRE_ER_UNC 6
`define ADRE_DH_LBA 6
`define ADRE_DH_FUA 7
`define ADRE_INT_DONE 0
`define ADRE_INT_ERR 1
`define ADRE_XM_8BIT 0

// ==========================================================
// reset values and sizes
`define ADRE_RST_DEVHEAD 8'ha0
`define ADRE_SECT_WORDS 9'h100
`define ADRE_CNT28_ZERO 17'h00100
`define ADRE_CNT48_ZERO 17'h10000

`endif

/* File: testbench/adre_chk.sv */
module adre_chk (
    input wire pclk,
    input wire presetn,
    input wire dmarq,
    input wire dmack_n,
    input wire dd_oe,
    input wire media_req,
    input wire [47:0] media_lba,
    input wire media_flush_req,
    input wire media_err,
    input wire intrq
);
    // ========================================
    // port relations
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_int_at_end: assert property ($rose(intrq) |-> !dmarq)
        else $error("interrupt while data pending");
    a_req_pulse: assert property (media_req |=> !media_req)
        else $error("fetch request longer than one cycle");
    a_lba_hold: assert property (!media_req |-> $stable(media_lba))
        else $error("fetch address moved without request");
    a_flush_first: assert property (media_flush_req |=> !media_req)
        else $error("fetch issued with flush");
    a_err_quiet: assert property (media_err && !dmarq |=> !dmarq [*4])
        else $error("request raised after media error");
    a_oe_needs_ack: assert property (dmack_n [*5] |-> !dd_oe)
        else $error("data driven without ack");
    a_no_fetch_drain: assert property (dmarq |-> !media_req)
        else $error("fetch while buffer drains");
    a_drop_holds: assert property ($fell(dmarq) |-> !dmarq [*8])
        else $error("request returned too soon");
endmodule // adre_chk

/* File: testbench/adre_host_model.sv */
module adre_host_model (
    input wire pclk,
    input wire presetn,
    input wire dmarq,
    input wire [15:0] dd_out,
    input wire dd_oe,
    input wire slow,
    output reg dmack_n,
    output reg iord_n,
    output reg [31:0] rx_cnt,
    output reg [31:0] rx_sum
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // dma drain, strobe low 3, high 7 or 21 cycles
    reg [4:0] t;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmack_n <= 1'b1;
            iord_n <= 1'b1;
            t <= 5'h00;
            rx_cnt <= 32'h0;
            rx_sum <= 32'h0;
        end else if (t != 5'h00) begin
            t <= t - 5'h01;
        end else if (!iord_n) begin
            // word counted on the rising strobe only if driven, summed always
            iord_n <= 1'b1;
            t <= slow ? 5'h14 : 5'h06;
            rx_cnt <= rx_cnt + {31'h0, dd_oe};
            rx_sum <= rx_sum + {16'h0, dd_out};
        end else if (dmarq && !dmack_n) begin
            iord_n <= 1'b0;
            t <= 5'h02;
        end else begin
            dmack_n <= !dmarq;
        end
    end
endmodule // adre_host_model

/* File: testbench/adre_read_engine_test.sv */
`include "adre_defs.vh"
`define CHK(nm, x, s) begin tests_run++; if ((s) !== (x)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, x, s); end end
module adre_read_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dmarq, dmack_n, iord_n;
    logic dd_oe, media_req, media_bypass_cache, media_flush_req, media_flush_done;
    logic media_wvalid, media_err, intrq, slow, byp, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, rx_cnt, rx_sum;
    logic [15:0] dd_out, media_wdata;
    logic [47:0] media_lba;
    int n_fail = 0, tests_run = 0, n_req = 0, n_flush = 0, err_req = 0;
    adre_read_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dmarq(dmarq), .dmack_n(dmack_n), .iord_n(iord_n),
        .dd_out(dd_out), .dd_oe(dd_oe), .media_req(media_req), .media_lba(media_lba),
        .media_bypass_cache(media_bypass_cache), .media_flush_req(media_flush_req),
        .media_flush_done(media_flush_done), .media_wvalid(media_wvalid),
        .media_wdata(media_wdata), .media_err(media_err), .intrq(intrq));
    adre_host_model host_u (.pclk(pclk), .presetn(presetn), .dmarq(dmarq), .dd_out(dd_out),
        .dd_oe(dd_oe), .slow(slow), .dmack_n(dmack_n), .iord_n(iord_n), .rx_cnt(rx_cnt),
        .rx_sum(rx_sum));
    // ========================================
    // media side: flush handshake, 256 words per fetch, or one media_err pulse and no words on fetch number err_req
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {media_flush_done, media_wvalid, media_err} = 3'h0;
        media_wdata = 16'h0;
        forever begin
            @(posedge pclk);
            if (media_flush_req) begin
                n_flush++;
                repeat (3) @(posedge pclk);
                media_flush_done <= 1'b1;
                @(posedge pclk);
                media_flush_done <= 1'b0;
            end else if (media_req) begin
                n_req++;
                byp = media_bypass_cache;
                if (n_req == err_req) begin
                    media_err <= 1'b1;
                    @(posedge pclk);
                    media_err <= 1'b0;
                end else begin
                    for (int i = 0; i < 256; i++) begin
                        media_wvalid <= 1'b1;
                        media_wdata <= {media_lba[7:0], i[7:0]};
                        @(posedge pclk);
                    end
                    media_wvalid <= 1'b0;
                    media_wdata <= ~media_wdata;
                end
            end
        end
    end
    task automatic finish_test;
        $display("checks %0d bad %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) begin
            n_fail++;
            finish_test;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, q)
    endtask
    task automatic wait_int;
        int n;
        n = 0;
        while (intrq !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000) begin
            n_fail++;
            finish_test;
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] ft, input logic [15:0] sc,
        input logic [23:0] lo, input logic [23:0] hi, input logic [7:0] dh);
        wr(`ADRE_REG_FEAT, {16'h0, ft});
        wr(`ADRE_REG_SCNT, {16'h0, sc});
        wr(`ADRE_REG_LBA_LO, {8'h0, lo});
        wr(`ADRE_REG_LBA_HI, {8'h0, hi});
        wr(`ADRE_REG_DEVHEAD, {24'h0, dh});
        wr(`ADRE_REG_CMD, {24'h0, op});
        wait_int;
    endtask
    function automatic logic [31:0] ssum(input logic [7:0] l);
        ssum = {8'h00, l, 16'h0000} + 32'h00007f80;
    endfunction
    task automatic t_c8;
        logic [31:0] c0, s0;
        c0 = rx_cnt;
        s0 = rx_sum;
        cmd(`ADRE_OP_READ_DMA, 16'h0, 16'h2, 24'h10, 24'h0, 8'he0);
        `CHK("words", 32'h200, rx_cnt - c0)
        `CHK("sum", ssum(8'h10) + ssum(8'h11), rx_sum - s0)
        rc(`ADRE_REG_LBA_LO, 32'h11, "last");
        rc(`ADRE_REG_STATUS, 32'h40, "status");
        rc(`ADRE_REG_INT_STAT, 32'h1, "done");
        wr(`ADRE_REG_INT_STAT, 32'h3);
        `CHK("intrq", 1'b0, intrq)
        $display("test c8 done");
    endtask
    task automatic t_ext;
        logic [31:0] c0, s0;
        c0 = rx_cnt;
        s0 = rx_sum;
        slow <= 1'b1;
        cmd(`ADRE_OP_READ_DMA_EXT, 16'h0, 16'h2, 24'hffffff, 24'h1, 8'he0);
        `CHK("words", 32'h200, rx_cnt - c0)
        `CHK("sum", ssum(8'hff) + ssum(8'h00), rx_sum - s0)
        rc(`ADRE_REG_LBA_LO, 32'h0, "last lo");
        rc(`ADRE_REG_LBA_HI, 32'h2, "last hi");
        wr(`ADRE_REG_INT_STAT, 32'h3);
        slow <= 1'b0;
        $display("test ext done");
    endtask
    task automatic t_err;
        err_req = n_req + 2;
        cmd(`ADRE_OP_READ_DMA_EXT, 16'h0, 16'h3, 24'h40, 24'h0, 8'he0);
        // words moved before the failure are not judged
        rc(`ADRE_REG_STATUS, 32'h41, "status");
        rc(`ADRE_REG_ERROR, 32'h40, "error");
        rc(`ADRE_REG_INT_STAT, 32'h2, "int err");
        rc(`ADRE_REG_LBA_LO, 32'h41, "fail lba");
        `CHK("fetches", err_req, n_req)
        err_req = 0;
        wr(`ADRE_REG_INT_STAT, 32'h3);
        $display("test err done");
    endtask
    task automatic t_abort;
        int r0;
        r0 = n_req;
        wr(`ADRE_REG_XMODE, 32'h1);
        wr(`ADRE_REG_INT_MASK, 32'h0);
        wr(`ADRE_REG_CMD, 32'h25);
        rc(`ADRE_REG_ERROR, 32'h4, "abort");
        rc(`ADRE_REG_INT_STAT, 32'h2, "int err");
        `CHK("masked", 1'b0, intrq)
        `CHK("fetches", r0, n_req)
        wr(`ADRE_REG_INT_MASK, 32'h3);
        `CHK("unmasked", 1'b1, intrq)
        wr(`ADRE_REG_INT_STAT, 32'h3);
        `CHK("cleared", 1'b0, intrq)
        wr(`ADRE_REG_XMODE, 32'h0);
        $display("test abort done");
    endtask
    task automatic t_fpdma;
        int f0;
        logic [31:0] c0;
        for (int f = 0; f < 2; f++) begin
            f0 = n_flush;
            c0 = rx_cnt;
            cmd(`ADRE_OP_READ_FPDMA, 16'h1, 16'h28, 24'h80, 24'h0, f ? 8'hc0 : 8'h40);
            `CHK("flush", f, n_flush - f0)
            `CHK("bypass", f[0], byp)
            `CHK("words", 32'h100, rx_cnt - c0)
            rc(`ADRE_REG_TAG, 32'h5, "tag");
            wr(`ADRE_REG_INT_STAT, 32'h3);
        end
        $display("test queued done");
    endtask
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        slow = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(`ADRE_REG_STATUS, 32'h40, "idle");
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 1'b1, e)
        wr(`ADRE_REG_INT_MASK, 32'h3);
        rc(`ADRE_REG_INT_MASK, 32'h3, "mask");
        $display("test regs done");
        t_c8;
        t_ext;
        t_err;
        t_abort;
        t_fpdma;
        finish_test;
    end
endmodule // adre_read_engine_test
bind adre_read_engine adre_chk chk_u (.pclk(pclk), .presetn(presetn), .dmarq(dmarq),
    .dmack_n(dmack_n), .dd_oe(dd_oe), .media_req(media_req), .media_lba(media_lba),
    .media_flush_req(media_flush_req), .media_err(media_err), .intrq(intrq));

/* File: verilog/adre_read_engine.v */
// Operation
// - read dma c8h: 1..256 sectors, count zero means 256
// - read dma ext 25h: 1..65536 sectors, count zero means 65536
// - ext command uses 48-bit lba from the address registers
// - start at the loaded address, walk consecutive sectors
// - on accept set busy, buffer data, then drq set and busy clear
// - dmarq held while buffered data remains for the host
// - interrupt only on whole transfer done, unrecoverable error or aborted command
// - 28-bit read leaves last sector address in the registers
// - ext read leaves last sector lba in the registers
// - error stops read and leaves failing sector address in registers
// - ext read with 8-bit mode enabled is aborted
// - queued read 60h moves data device to host
// - fua set: flush dirty cache, then read from media
// - fua clear: data may come from media or cache
// - queued read count in features, zero is 65536; tag in count
// - command end clears busy and raises interrupt
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "adre_defs.vh"

module adre_read_engine (
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // dma pins toward the host
    output wire dmarq,
    input wire dmack_n,
    input wire iord_n,
    output reg [15:0] dd_out,
    output reg dd_oe,
    // media back end, same clock
    output reg media_req,
    output reg [47:0] media_lba,
    output reg media_bypass_cache,
    output reg media_flush_req,
    input wire media_flush_done,
    input wire media_wvalid,
    input wire [15:0] media_wdata,
    input wire media_err,
    output wire intrq
);

    // ==========================================================
    // states
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_FLUSH = 6'b000010;
    localparam [5:0] S_REQ = 6'b000100;
    localparam [5:0] S_FILL = 6'b001000;
    localparam [5:0] S_DRAIN = 6'b010000;
    localparam [5:0] S_END = 6'b100000;

    reg [5:0] state;
    // task file
    reg [15:0] feat;
    reg [15:0] scnt;
    reg [23:0] lba_lo;
    reg [23:0] lba_hi;
    reg [7:0] devhead;
    // status and interrupts
    reg bsy;
    reg drq;
    reg err;
    reg [7:0] error_reg;
    reg xmode_8bit;
    reg [1:0] int_stat;
    reg [1:0] int_mask;
    reg [4:0] ncq_tag;
    // transfer progress
    reg is_ext;
    reg [47:0] cur_lba;
    reg [16:0] remaining;
    reg [15:0] sect_buf [0:255];
    reg [8:0] wr_cnt;
    reg [8:0] rd_cnt;
    // pin sync stages
    reg dmack_s1, dmack_s2;
    reg iord_s1, iord_s2, iord_s3;
    reg ev_done, ev_err;

    wire wr_acc = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire cmd_wr = wr_acc && (paddr == `ADRE_REG_CMD) && state == S_IDLE;
    wire [7:0] opcode = pwdata[7:0];
    wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `ADRE_REG_TAG);
    // task-file writes only land while idle
    wire tf_wr = wr_acc && (state == S_IDLE);
    wire int_wr = wr_acc && (paddr == `ADRE_REG_INT_STAT);
    wire [1:0] int_ev;
    wire [7:0] status_byte;

    // ==========================================================
    // sector counts and start address per command
    // zero count is the largest transfer, never an empty one
    wire [16:0] cnt28 = (scnt[7:0] == 8'h00) ? `ADRE_CNT28_ZERO : {9'h000, scnt[7:0]};
    wire [16:0] cnt48 = (scnt == 16'h0000) ? `ADRE_CNT48_ZERO : {1'b0, scnt};
    wire [16:0] cntq = (feat == 16'h0000) ? `ADRE_CNT48_ZERO : {1'b0, feat};
    // chs taken as linear, head nibble on top of the low word
    wire [47:0] lba28 = {20'h00000, devhead[3:0], lba_lo};
    wire [47:0] lba48 = {lba_hi, lba_lo};

    // ==========================================================
    // buffer pointers
    wire fill_full = (wr_cnt == `ADRE_SECT_WORDS);
    wire drain_empty = (rd_cnt == `ADRE_SECT_WORDS);
    wire last_sect = (remaining == 17'h00001);
    // word taken on the rising edge of iord while dmack held low
    wire word_pop = (state == S_DRAIN) && ~dmack_s2 && iord_s2 && ~iord_s3;

    // no wait states: every register answers in the access cycle
    assign pready = 1'b1;
    // holes and unaligned offsets report an error, no effect
    assign pslverr = psel & penable & ~mapped;
    assign dmarq = (state == S_DRAIN) && !drain_empty;
    assign intrq = |(int_stat & int_mask);

    // ==========================================================
    // status byte
    // drdy is simply not busy: no standby or fault states here
    assign status_byte[`ADRE_ST_BSY] = bsy;
    assign status_byte[`ADRE_ST_DRDY] = ~bsy;
    assign status_byte[5] = 1'b0;
    assign status_byte[4] = 1'b0;
    assign status_byte[`ADRE_ST_DRQ] = drq;
    assign status_byte[2] = 1'b0;
    assign status_byte[1] = 1'b0;
    assign status_byte[`ADRE_ST_ERR] = err;
    assign int_ev[`ADRE_INT_DONE] = ev_done;
    assign int_ev[`ADRE_INT_ERR] = ev_err;

    // ==========================================================
    // pin synchronisers
    // iord gets a third stage for its edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmack_s1 <= 1'b1;
            dmack_s2 <= 1'b1;
            iord_s1 <= 1'b1;
            iord_s2 <= 1'b1;
            iord_s3 <= 1'b1;
        end else begin
            dmack_s1 <= dmack_n;
            dmack_s2 <= dmack_s1;
            iord_s1 <= iord_n;
            iord_s2 <= iord_s1;
            iord_s3 <= iord_s2;
        end
    end

    // ==========================================================
    // sector buffer, no reset so it maps to ram
    // one sector deep: fill, then drain, no overlap
    always @(posedge pclk) begin
        if (state == S_FILL && media_wvalid && !fill_full)
            sect_buf[wr_cnt[7:0]] <= media_wdata;
    end

    // word under the read pointer, one cycle late
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dd_out <= 16'h0000;
            dd_oe <= 1'b0;
        end else begin
            dd_out <= sect_buf[rd_cnt[7:0]];
            dd_oe <= (state == S_DRAIN) && ~dmack_s2;
        end
    end

    // ==========================================================
    // apb read data
    // loaded in the setup cycle, so reads need no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `ADRE_REG_FEAT: prdata <= {16'h0000, feat};
                `ADRE_REG_SCNT: prdata <= {16'h0000, scnt};
                `ADRE_REG_LBA_LO: prdata <= {8'h00, lba_lo};
                `ADRE_REG_LBA_HI: prdata <= {8'h00, lba_hi};
                `ADRE_REG_DEVHEAD: prdata <= {24'h000000, devhead};
                `ADRE_REG_STATUS: prdata <= {24'h000000, status_byte};
                `ADRE_REG_ERROR: prdata <= {24'h000000, error_reg};
                `ADRE_REG_XMODE: prdata <= {31'h00000000, xmode_8bit};
                `ADRE_REG_INT_STAT: prdata <= {30'h00000000, int_stat};
                `ADRE_REG_INT_MASK: prdata <= {30'h00000000, int_mask};
                `ADRE_REG_TAG: prdata <= {27'h0000000, ncq_tag};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // mask and transfer mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= 2'b00;
            xmode_8bit <= 1'b0;
        end else begin
            if (wr_acc && paddr == `ADRE_REG_INT_MASK)
                int_mask <= pwdata[1:0];
            if (wr_acc && paddr == `ADRE_REG_XMODE)
                xmode_8bit <= pwdata[`ADRE_XM_8BIT];
        end
    end

    // ==========================================================
    // interrupt status, one sticky bit per event
    // set wins over write-one-clear so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_int
            always @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    int_stat[gi] <= 1'b0;
                else
                    int_stat[gi] <= int_ev[gi] | (int_stat[gi] & ~(int_wr & pwdata[gi]));
            end
        end
    endgenerate

    // ==========================================================
    // task file and command engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            feat <= 16'h0000;
            scnt <= 16'h0000;
            lba_lo <= 24'h000000;
            lba_hi <= 24'h000000;
            devhead <= `ADRE_RST_DEVHEAD;
            bsy <= 1'b0;
            drq <= 1'b0;
            err <= 1'b0;
            error_reg <= 8'h00;
            ncq_tag <= 5'h00;
            is_ext <= 1'b0;
            cur_lba <= 48'h000000000000;
            remaining <= 17'h00000;
            wr_cnt <= 9'h000;
            rd_cnt <= 9'h000;
            media_req <= 1'b0;
            media_lba <= 48'h000000000000;
            media_bypass_cache <= 1'b0;
            media_flush_req <= 1'b0;
            ev_done <= 1'b0;
            ev_err <= 1'b0;
        end else begin
            media_req <= 1'b0;
            media_flush_req <= 1'b0;
            ev_done <= 1'b0;
            ev_err <= 1'b0;
            // task file is writable only while idle
            if (tf_wr) begin
                case (paddr)
                    `ADRE_REG_FEAT: feat <= pwdata[15:0];
                    `ADRE_REG_SCNT: scnt <= pwdata[15:0];
                    `ADRE_REG_LBA_LO: lba_lo <= pwdata[23:0];
                    `ADRE_REG_LBA_HI: lba_hi <= pwdata[23:0];
                    `ADRE_REG_DEVHEAD: devhead <= pwdata[7:0];
                    default: ;
                endcase
            end
            case (state)
                S_IDLE: begin
                    if (cmd_wr) begin
                        err <= 1'b0;
                        error_reg <= 8'h00;
                        media_bypass_cache <= 1'b0;
                        if (opcode == `ADRE_OP_READ_DMA) begin
                            is_ext <= 1'b0;
                            cur_lba <= lba28;
                            remaining <= cnt28;
                            bsy <= 1'b1;
                            state <= S_REQ;
                        end else if (opcode == `ADRE_OP_READ_DMA_EXT && !xmode_8bit) begin
                            is_ext <= 1'b1;
                            cur_lba <= lba48;
                            remaining <= cnt48;
                            bsy <= 1'b1;
                            state <= S_REQ;
                        end else if (opcode == `ADRE_OP_READ_FPDMA) begin
                            is_ext <= 1'b1;
                            // runs at once; the tag is only reported back
                            cur_lba <= lba48;
                            remaining <= cntq;
                            ncq_tag <= scnt[7:3];
                            bsy <= 1'b1;
                            if (devhead[`ADRE_DH_FUA]) begin
                                media_bypass_cache <= 1'b1;
                                media_flush_req <= 1'b1;
                                state <= S_FLUSH;
                            end else begin
                                state <= S_REQ;
                            end
                        end else begin
                            // 8-bit mode ext read and unknown opcodes abort
                            err <= 1'b1;
                            error_reg[`ADRE_ER_ABRT] <= 1'b1;
                            ev_err <= 1'b1;
                        end
                    end
                end
                S_FLUSH: begin
                    // dirty cached copy reaches media before the read
                    if (media_flush_done)
                        state <= S_REQ;
                end
                S_REQ: begin
                    // one sector per fetch, pointers restart
                    media_req <= 1'b1;
                    media_lba <= cur_lba;
                    wr_cnt <= 9'h000;
                    rd_cnt <= 9'h000;
                    state <= S_FILL;
                end
                S_FILL: begin
                    // failing sector is never offered to the host
                    if (media_err) begin
                        state <= S_END;
                        err <= 1'b1;
                        error_reg[`ADRE_ER_UNC] <= 1'b1;
                    end else if (fill_full) begin
                        bsy <= 1'b0;
                        drq <= 1'b1;
                        state <= S_DRAIN;
                    end else if (media_wvalid) begin
                        wr_cnt <= wr_cnt + 9'h001;
                    end
                end
                S_DRAIN: begin
                    // next fetch waits for an empty buffer: one buffer
                    // keeps area low at the cost of throughput
                    if (drain_empty) begin
                        if (last_sect) begin
                            state <= S_END;
                        end else begin
                            remaining <= remaining - 17'h00001;
                            cur_lba <= cur_lba + 48'h000000000001;
                            state <= S_REQ;
                        end
                    end else if (word_pop) begin
                        rd_cnt <= rd_cnt + 9'h001;
                    end
                end
                S_END: begin
                    // last or failing sector address back to the task file
                    lba_lo <= cur_lba[23:0];
                    if (is_ext)
                        lba_hi <= cur_lba[47:24];
                    else
                        devhead[3:0] <= cur_lba[27:24];
                    bsy <= 1'b0;
                    drq <= 1'b0;
                    ev_done <= ~err;
                    ev_err <= err;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule // adre_read_engine
